// ---- design/mecd_pkg.sv ----
// Types shared by the EEE and duplex control block.
package mecd_pkg;

   // ==========================================================
   // Transmit low power idle states
   typedef enum logic [2:0] {
      LPI_ACTIVE = 3'h1,
      LPI_IDLE   = 3'h2,
      LPI_EXITED = 3'h4
   } mecd_lpi_st_t;

endpackage

// ---- design/mecd_regs.svh ----
// Register offsets, field positions, reset values and codes of the EEE and duplex control block.
`ifndef MECD_REGS_SVH
`define MECD_REGS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define MECD_OFS_OPCTL      12'h100
`define MECD_OFS_EXIT_WAIT  12'h104
`define MECD_OFS_PROTECT    12'h108

// ==========================================================
// Field positions in mac_operating_control, and of the protect bit in the protect register
`define MECD_BIT_RX_ON      0
`define MECD_BIT_TX_ON      1
`define MECD_BIT_DPX_SEL    3
`define MECD_BIT_AUTO_DPX   12
`define MECD_BIT_DPX_POL    13
`define MECD_BIT_SELF_EXIT  16
`define MECD_BIT_EEE_ON     17
`define MECD_BIT_GATE_ON    18
`define MECD_BIT_PROTECT    0

// ==========================================================
// Reset values
`define MECD_RST_GATE_ON    1'h0
`define MECD_RST_EEE_ON     1'h0
`define MECD_RST_SELF_EXIT  1'h0
`define MECD_RST_DPX_POL    1'h1
`define MECD_RST_AUTO_DPX   1'h0
`define MECD_RST_DPX_SEL    1'h0
`define MECD_RST_PROTECT    1'h0

// ==========================================================
// Link speed code for the speed that uses the GMII transmit clock
`define MECD_SPEED_1000     2'h2

`endif

// ---- design/mecd_top.sv ----
// EEE low power idle control and duplex handling of the MAC operating control register.
//
// How it works
// - TX clock gate bit 18 stops the GMII transmit clock during TX LPI.
// - The clock gate has no effect unless the link runs at 1000 Mbps.
// - EEE enable bit 17 turns LPI on; cleared, all LPI activity stops.
// - LPI requests go to the PHY even with the transmitter off.
// - PHY LPI indications are recognised even with the receiver off.
// - Self exit bit 16 ends TX LPI once the programmed wait expires.
// - The wait starts when LPI signalling starts; length from wait register.
// - Polarity bit 13, reset 1: 1 means high duplex pin is full duplex.
// - Auto duplex bit 12 takes duplex from the PHY pin, not the bit.
// - Under auto duplex the duplex bit reads the detected state.
// - Bits 18,17,16,13,12 survive soft resets while protection is set.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ns
`include "mecd_regs.svh"

module mecd_top #(
   parameter int WAIT_W = 32
) (
   input  wire logic        CORE_CLK_I,            // Core clock, 100 MHz.
   input  wire logic        RST_N_I,               // Synchronous reset, active low.
   input  wire logic        SOFT_RST_I,            // Soft reset pulse, maskable.
   input  wire logic [11:0] ADDR_I,                // Register byte address.
   input  wire logic [31:0] WDATA_I,               // Write data.
   input  wire logic        WR_I,                  // Write strobe.
   input  wire logic        RD_I,                  // Read strobe.
   output logic      [31:0] RDATA_O,               // Read data, cycle after RD_I.
   input  wire logic [1:0]  LINK_SPEED_I,          // Current link speed code.
   input  wire logic        TX_LPI_REQ_I,          // MAC wants to enter TX LPI.
   output logic             TX_LPI_O,              // LPI request toward the PHY.
   output logic             GTX_CLK_EN_O,          // Low stops GMII transmit clock.
   input  wire logic        RX_CLK_I,              // GMII receive clock from PHY.
   input  wire logic        RX_LPI_IND_I,          // PHY LPI indication pin.
   output logic             RX_LPI_O,              // Recognised receive LPI.
   input  wire logic        PHY_FULL_DUPLEX_IND_I, // PHY duplex indicator pin.
   output logic             FULL_DUPLEX_O,         // Duplex mode in use.
   output logic             RECEIVER_ON_O,         // Receiver enable bit.
   output logic             TRANSMITTER_ON_O       // Transmitter enable bit.
);

   // ==========================================================
   // State
   typedef struct packed {
      logic                 gate_on;
      logic                 eee_on;
      logic                 self_exit_on;
      logic                 dpx_pol;
      logic                 auto_dpx;
      logic                 dpx_sel;
      logic                 rx_on;
      logic                 tx_on;
      logic                 protect;
      logic [WAIT_W-1:0]    exit_wait;
      mecd_pkg::mecd_lpi_st_t lpi_st;
      logic [WAIT_W-1:0]    cnt;
      logic [2:0]           rxlpi_s;
      logic [2:0]           dpx_s;
      logic [2:0]           clk_s;
      logic                 clk_lvl;
      logic                 rx_lpi;
      logic                 dpx_det;
      logic [31:0]          rdata;
   } mecd_state_t;

   mecd_state_t s;
   mecd_state_t next_s;
   logic        speed_gbe;
   logic        clk_rise;
   logic [31:0] rd;

   assign speed_gbe = (LINK_SPEED_I == `MECD_SPEED_1000);
   // A link clock edge counts once the second and third stages agree.
   assign clk_rise  = s.clk_s[1] & s.clk_s[2] & ~s.clk_lvl;

   // ==========================================================
   // Read mux
   always_comb begin
      rd = 32'h0;
      case (ADDR_I)
         `MECD_OFS_OPCTL: begin
            rd[`MECD_BIT_RX_ON]     = s.rx_on;
            rd[`MECD_BIT_TX_ON]     = s.tx_on;
            rd[`MECD_BIT_DPX_SEL]   = s.auto_dpx ? s.dpx_det : s.dpx_sel;
            rd[`MECD_BIT_AUTO_DPX]  = s.auto_dpx;
            rd[`MECD_BIT_DPX_POL]   = s.dpx_pol;
            rd[`MECD_BIT_SELF_EXIT] = s.self_exit_on;
            rd[`MECD_BIT_EEE_ON]    = s.eee_on;
            rd[`MECD_BIT_GATE_ON]   = s.gate_on;
         end
         `MECD_OFS_EXIT_WAIT: begin
            rd[WAIT_W-1:0] = s.exit_wait;
         end
         `MECD_OFS_PROTECT: begin
            rd[`MECD_BIT_PROTECT] = s.protect;
         end
         default: begin
            rd = 32'h0;
         end
      endcase
   end

   // ==========================================================
   // Next state
   always_comb begin
      next_s = s;
      next_s.rdata = RD_I ? rd : 32'h0;

      // Pin synchronisers: stage 0 feeds only stage 1.
      next_s.clk_s   = {s.clk_s[1:0], RX_CLK_I};
      next_s.rxlpi_s = {s.rxlpi_s[1:0], RX_LPI_IND_I};
      next_s.dpx_s   = {s.dpx_s[1:0], PHY_FULL_DUPLEX_IND_I};
      if (s.clk_s[1] == s.clk_s[2]) begin
         next_s.clk_lvl = s.clk_s[2];
      end

      if (s.dpx_s[1] == s.dpx_s[2]) begin
         next_s.dpx_det = (s.dpx_s[2] == s.dpx_pol);
      end

      if (!s.eee_on) begin
         next_s.rx_lpi = 1'b0;
      end else if (clk_rise && s.rxlpi_s[1] == s.rxlpi_s[2]) begin
         next_s.rx_lpi = s.rxlpi_s[2];
      end

      // Register writes. Reserved bits are simply not stored.
      if (WR_I) begin
         case (ADDR_I)
            `MECD_OFS_OPCTL: begin
               next_s.rx_on        = WDATA_I[`MECD_BIT_RX_ON];
               next_s.tx_on        = WDATA_I[`MECD_BIT_TX_ON];
               next_s.dpx_sel      = WDATA_I[`MECD_BIT_DPX_SEL];
               next_s.auto_dpx     = WDATA_I[`MECD_BIT_AUTO_DPX];
               next_s.dpx_pol      = WDATA_I[`MECD_BIT_DPX_POL];
               next_s.self_exit_on = WDATA_I[`MECD_BIT_SELF_EXIT];
               next_s.eee_on       = WDATA_I[`MECD_BIT_EEE_ON];
               next_s.gate_on      = WDATA_I[`MECD_BIT_GATE_ON];
            end
            `MECD_OFS_EXIT_WAIT: begin
               next_s.exit_wait = WDATA_I[WAIT_W-1:0];
            end
            `MECD_OFS_PROTECT: begin
               next_s.protect = WDATA_I[`MECD_BIT_PROTECT];
            end
            default: begin
               next_s.protect = s.protect;
            end
         endcase
      end

      // Transmit LPI sequence.
      case (s.lpi_st)
         mecd_pkg::LPI_ACTIVE: begin
            if (s.eee_on && TX_LPI_REQ_I) begin
               next_s.lpi_st = mecd_pkg::LPI_IDLE;
               next_s.cnt    = s.exit_wait;
            end
         end
         mecd_pkg::LPI_IDLE: begin
            if (!TX_LPI_REQ_I) begin
               next_s.lpi_st = mecd_pkg::LPI_ACTIVE;
            end else if (s.self_exit_on && s.cnt == '0) begin
               next_s.lpi_st = mecd_pkg::LPI_EXITED;
            end else if (s.cnt != '0) begin
               next_s.cnt = s.cnt - 1'b1;
            end
         end
         mecd_pkg::LPI_EXITED: begin
            // Stay out of LPI until the MAC drops its request.
            if (!TX_LPI_REQ_I) begin
               next_s.lpi_st = mecd_pkg::LPI_ACTIVE;
            end
         end
         default: begin
            next_s.lpi_st = mecd_pkg::LPI_ACTIVE;
         end
      endcase
      if (!s.eee_on) begin
         next_s.lpi_st = mecd_pkg::LPI_ACTIVE;
      end

      // A soft reset always clears the enables and the sequence. The
      // protected fields keep their value only while protection is set.
      if (SOFT_RST_I) begin
         next_s.rx_on   = 1'b0;
         next_s.tx_on   = 1'b0;
         next_s.dpx_sel = `MECD_RST_DPX_SEL;
         next_s.lpi_st  = mecd_pkg::LPI_ACTIVE;
         next_s.rx_lpi  = 1'b0;
         if (!s.protect) begin
            next_s.gate_on      = `MECD_RST_GATE_ON;
            next_s.eee_on       = `MECD_RST_EEE_ON;
            next_s.self_exit_on = `MECD_RST_SELF_EXIT;
            next_s.dpx_pol      = `MECD_RST_DPX_POL;
            next_s.auto_dpx     = `MECD_RST_AUTO_DPX;
         end else begin
            // The soft reset also wins over a write in the same cycle.
            next_s.gate_on      = s.gate_on;
            next_s.eee_on       = s.eee_on;
            next_s.self_exit_on = s.self_exit_on;
            next_s.dpx_pol      = s.dpx_pol;
            next_s.auto_dpx     = s.auto_dpx;
         end
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         s              <= '0;
         s.gate_on      <= `MECD_RST_GATE_ON;
         s.eee_on       <= `MECD_RST_EEE_ON;
         s.self_exit_on <= `MECD_RST_SELF_EXIT;
         s.dpx_pol      <= `MECD_RST_DPX_POL;
         s.auto_dpx     <= `MECD_RST_AUTO_DPX;
         s.dpx_sel      <= `MECD_RST_DPX_SEL;
         s.protect      <= `MECD_RST_PROTECT;
         s.lpi_st       <= mecd_pkg::LPI_ACTIVE;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // Outputs
   assign RDATA_O          = s.rdata;
   assign TX_LPI_O         = (s.lpi_st == mecd_pkg::LPI_IDLE);
   assign GTX_CLK_EN_O     = ~(TX_LPI_O & s.gate_on & speed_gbe);
   assign RX_LPI_O         = s.rx_lpi;
   assign FULL_DUPLEX_O    = s.auto_dpx ? s.dpx_det : s.dpx_sel;
   assign RECEIVER_ON_O    = s.rx_on;
   assign TRANSMITTER_ON_O = s.tx_on;

   // ==========================================================
   // Checks
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RST_N_I);

   a_clk_gate_lpi: assert property (
      TX_LPI_O && s.gate_on && speed_gbe |-> !GTX_CLK_EN_O)
      else $error("Transmit clock runs during gated LPI.");

   a_gate_speed_only: assert property (
      !speed_gbe |-> GTX_CLK_EN_O)
      else $error("Transmit clock stopped at a non gigabit speed.");

   a_eee_off_quiet: assert property (
      !s.eee_on && !$past(s.eee_on) |-> !TX_LPI_O && !RX_LPI_O)
      else $error("LPI activity while EEE disabled.");

   a_lpi_req_taken: assert property (
      s.eee_on && TX_LPI_REQ_I && !SOFT_RST_I
      && s.lpi_st == mecd_pkg::LPI_ACTIVE |=> TX_LPI_O)
      else $error("LPI request not issued.");

   a_rx_lpi_seen: assert property (
      s.eee_on && clk_rise && s.rxlpi_s[1] && s.rxlpi_s[2] && !SOFT_RST_I
      |=> RX_LPI_O)
      else $error("PHY LPI indication not recognised.");

   a_self_exit_end: assert property (
      TX_LPI_O && s.self_exit_on && s.cnt == '0 |=> !TX_LPI_O)
      else $error("LPI not removed after the wait.");

   a_wait_loaded: assert property (
      $rose(TX_LPI_O) |-> s.cnt == $past(s.exit_wait))
      else $error("Removal wait not loaded at LPI start.");

   a_dpx_polarity: assert property (
      s.dpx_s[1] == s.dpx_s[2] |=> s.dpx_det == ($past(s.dpx_s[2]) == $past(s.dpx_pol)))
      else $error("Duplex pin read with wrong polarity.");

   a_dpx_source: assert property (
      s.auto_dpx && !WR_I && !SOFT_RST_I && s.dpx_s[1] == s.dpx_s[2]
      |=> FULL_DUPLEX_O == ($past(s.dpx_s[2]) == $past(s.dpx_pol)))
      else $error("Duplex taken from the wrong source.");

   a_dpx_readback: assert property (
      RD_I && ADDR_I == `MECD_OFS_OPCTL && s.auto_dpx
      |=> RDATA_O[`MECD_BIT_DPX_SEL] == $past(s.dpx_det))
      else $error("Duplex bit does not read detected state.");

   a_protect_keep: assert property (
      SOFT_RST_I && s.protect |=> s.eee_on == $past(s.eee_on)
      && s.dpx_pol == $past(s.dpx_pol) && s.gate_on == $past(s.gate_on))
      else $error("Protected field lost on soft reset.");

   a_rsvd_zero: assert property (
      RD_I && ADDR_I == `MECD_OFS_OPCTL
      |=> RDATA_O[31:19] == 13'h0 && RDATA_O[15:14] == 2'h0)
      else $error("Reserved bits read nonzero.");

endmodule

// ---- sim/mecd_phy_model.sv ----
// Behavioural PHY on the far side of the GMII: receive clock, LPI indication, duplex pin.
`timescale 1ns/1ns

module mecd_phy_model #(
   parameter logic STOP_CAP = 1'h1
) (
   input  wire logic lpi_i,      // Ask the PHY to signal receive LPI.
   input  wire logic fdx_i,      // Raw level wanted on the duplex pin.
   output logic      rx_clk_o,   // Receive clock, 125 ns period.
   output logic      rx_lpi_o,   // LPI indication pin.
   output logic      fdx_o,      // Duplex indicator pin.
   output logic      stop_cap_o  // High when a stopped TX clock is tolerated.
);
   // ==========================================================
   // Receive side
   // Pins move on the falling receive edge so the MAC never sees them change with its key edge.
   initial begin
      rx_clk_o = 1'b0;
      rx_lpi_o = 1'b0;
      fdx_o    = 1'b0;
      forever begin
         #62 rx_clk_o = 1'b1;
         #63 rx_clk_o = 1'b0;
      end
   end

   always @(negedge rx_clk_o) begin
      rx_lpi_o <= lpi_i;
      fdx_o    <= fdx_i;
   end

   assign stop_cap_o = STOP_CAP;
endmodule

// ---- sim/mecd_top_test.sv ----
// Self-checking bench of the EEE and duplex control block.
`timescale 1ns/1ns
`include "mecd_regs.svh"

module mecd_top_test;
   logic        clk, rst_n, soft_rst, wr, rd, tx_req, lpi, fdx;
   logic [11:0] addr;
   logic [31:0] wdata, rdata;
   logic [1:0]  speed;
   logic        tx_lpi, gtx_en, rx_clk, rx_ind, rx_lpi, fdx_pin, full_dpx, cap;
   logic        rx_on, tx_on;
   logic [75:0] rows [8];
   int          err_total, tests_run;

   mecd_top #(.WAIT_W(32)) u_mecd_top (
      .CORE_CLK_I(clk), .RST_N_I(rst_n), .SOFT_RST_I(soft_rst), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .LINK_SPEED_I(speed),
      .TX_LPI_REQ_I(tx_req), .TX_LPI_O(tx_lpi), .GTX_CLK_EN_O(gtx_en), .RX_CLK_I(rx_clk),
      .RX_LPI_IND_I(rx_ind), .RX_LPI_O(rx_lpi), .PHY_FULL_DUPLEX_IND_I(fdx_pin),
      .FULL_DUPLEX_O(full_dpx), .RECEIVER_ON_O(rx_on), .TRANSMITTER_ON_O(tx_on));

   mecd_phy_model u_mecd_phy_model (
      .lpi_i(lpi), .fdx_i(fdx), .rx_clk_o(rx_clk), .rx_lpi_o(rx_ind), .fdx_o(fdx_pin),
      .stop_cap_o(cap));

   // ==========================================================
   // Bus tasks and checks
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp, input string name);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      chk(name, exp, rdata);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic soft_pulse();
      @(posedge clk);
      soft_rst <= 1'b1;
      @(posedge clk);
      soft_rst <= 1'b0;
   endtask

   task automatic end_sim();
      if (err_total == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ==========================================================
   // Clock and register table: address, write data, value read back
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // each row changes polarity or auto duplex only after RX and TX were off.
   initial rows = '{{12'h100, 32'hfff7_c00b, 32'h0007_000b}, {12'h100, 32'h0005_0008, 32'h0005_0008},
                    {12'h100, 32'h0000_2000, 32'h0000_2000}, {12'h104, 32'hffff_ffff, 32'hffff_ffff},
                    {12'h104, 32'h0000_0005, 32'h0000_0005}, {12'h108, 32'hffff_ffff, 32'h0000_0001},
                    {12'h108, 32'h0000_0000, 32'h0000_0000}, {12'h10c, 32'h0000_1234, 32'h0000_0000}};

   // ==========================================================
   // Main sequence
   initial begin
      int         n;
      logic       f;
      logic [1:0] b;
      {rst_n, soft_rst, wr, rd, tx_req, lpi, fdx} = '0;
      addr = '0;
      wdata = '0;
      speed = 2'h2;
      err_total = 0;
      tests_run = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(`MECD_OFS_OPCTL, 32'h0000_2000, "opctl_rst");
      rd_reg(`MECD_OFS_EXIT_WAIT, 32'h0, "wait_rst");
      for (int k = 0; k < 8; k++) begin
         wr_reg(rows[k][75:64], rows[k][63:32]);
         rd_reg(rows[k][75:64], rows[k][31:0], "row");
      end
      // no LPI while EEE is off
      @(posedge clk);
      tx_req <= 1'b1;
      cyc(3);
      chk("lpi_off", 32'h0, {31'h0, tx_lpi});
      @(posedge clk);
      tx_req <= 1'b0;
      // gate set only when the PHY tolerates it
      if (cap === 1'b1) begin
         wr_reg(`MECD_OFS_OPCTL, 32'h0006_2000);
      end
      @(posedge clk);
      tx_req <= 1'b1;
      cyc(2);
      chk("lpi_on", 32'h1, {31'h0, tx_lpi});
      chk("gate_1000", 32'h0, {31'h0, gtx_en});
      @(posedge clk);
      speed <= 2'h1;
      #1;
      chk("gate_100", 32'h1, {31'h0, gtx_en});
      @(posedge clk);
      speed  <= 2'h2;
      tx_req <= 1'b0;
      cyc(2);
      chk("lpi_end", 32'h0, {31'h0, tx_lpi});
      chk("gate_end", 32'h1, {31'h0, gtx_en});
      // self exit changed only with EEE off
      wr_reg(`MECD_OFS_OPCTL, 32'h0000_2000);
      wr_reg(`MECD_OFS_OPCTL, 32'h0001_2000);
      wr_reg(`MECD_OFS_OPCTL, 32'h0003_2000);
      @(posedge clk);
      tx_req <= 1'b1;
      n = 0;
      repeat (20) begin
         cyc(1);
         if (tx_lpi === 1'b1) n++;
      end
      chk("self_exit_len", 32'd6, n);
      chk("self_exit_low", 32'h0, {31'h0, tx_lpi});
      @(posedge clk);
      tx_req <= 1'b0;
      lpi    <= 1'b1;
      n = 0;
      while (rx_lpi !== 1'b1 && n < 60) begin
         cyc(1);
         n++;
      end
      if (rx_lpi !== 1'b1) begin
         err_total++;
         end_sim();
      end
      chk("rx_lpi", 32'h1, {31'h0, rx_lpi});
      wr_reg(`MECD_OFS_OPCTL, 32'h0001_2000);
      cyc(2);
      chk("rx_lpi_off", 32'h0, {31'h0, rx_lpi});
      @(posedge clk);
      lpi <= 1'b0;
      // polarity and auto duplex change only with RX and TX off
      wr_reg(`MECD_OFS_OPCTL, 32'h0000_2008);
      cyc(25);
      chk("dpx_manual", 32'h1, {31'h0, full_dpx});
      for (int i = 0; i < 4; i++) begin
         b = 2'(i);
         f = (b[0] == b[1]);
         wr_reg(`MECD_OFS_OPCTL, 32'h0000_1008 | {18'h0, b[1], 13'h0});
         fdx <= b[0];
         cyc(25);
         chk("dpx_auto", {31'h0, f}, {31'h0, full_dpx});
         rd_reg(`MECD_OFS_OPCTL, {18'h0, b[1], 9'h100, f, 3'h0}, "dpx_read");
      end
      // protected bits survive a soft reset
      wr_reg(`MECD_OFS_PROTECT, 32'h1);
      wr_reg(`MECD_OFS_OPCTL, 32'h0007_2003);
      #1;
      chk("enables_on", 32'h3, {30'h0, tx_on, rx_on});
      soft_pulse();
      rd_reg(`MECD_OFS_OPCTL, 32'h0007_2000, "protect_on");
      chk("enables_off", 32'h0, {30'h0, tx_on, rx_on});
      wr_reg(`MECD_OFS_PROTECT, 32'h0);
      soft_pulse();
      rd_reg(`MECD_OFS_OPCTL, 32'h0000_2000, "protect_off");
      // a hard reset in mid-run returns even the protected fields to their reset values
      wr_reg(`MECD_OFS_PROTECT, 32'h1);
      wr_reg(`MECD_OFS_OPCTL, 32'h0007_1000);
      wr_reg(`MECD_OFS_EXIT_WAIT, 32'h0000_0009);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk("dpx_hard", 32'h0, {31'h0, full_dpx});
      chk("gate_hard", 32'h1, {31'h0, gtx_en});
      chk("lpi_hard", 32'h0, {30'h0, tx_lpi, rx_lpi});
      rd_reg(`MECD_OFS_PROTECT, 32'h0, "hard_protect");
      rd_reg(`MECD_OFS_EXIT_WAIT, 32'h0, "hard_wait");
      rd_reg(`MECD_OFS_OPCTL, 32'h0000_2000, "hard_opctl");
      cyc(1);
      chk("rdata_idle", 32'h0, rdata);
      end_sim();
   end
endmodule
